// >>> rtl/ebus_pkg.sv
// constants and types for the expansion bus port controller
// assumes a 32-bit apb host; each register takes one aligned word
`default_nettype none
package ebus_pkg;
    // register indices; byte address is index times four
    localparam logic [7:0] IDX_PA = 8'h00;
    localparam logic [7:0] IDX_PB = 8'h01;
    localparam logic [7:0] IDX_DA = 8'h02;
    localparam logic [7:0] IDX_DB = 8'h03;
    localparam logic [7:0] IDX_PE = 8'h08;
    localparam logic [7:0] IDX_DE = 8'h09;
    localparam logic [7:0] IDX_ASSIGN = 8'h0a;
    localparam logic [7:0] IDX_MODE = 8'h10;
    localparam logic [7:0] IDX_PULL = 8'h11;
    // indices below this leave the map in peripheral mode
    localparam logic [7:0] IDX_BUS_LIMIT = 8'h10;
    // mode register fields
    localparam int MODE_LO = 0;
    localparam int MODE_HI = 1;
    localparam int EME_BIT = 2;
    localparam int NARROW_FOLLOW_SPACE_BIT_BIT = 3;
    localparam logic [7:0] MODE_MASK = 8'h0f;
    // assignment register fields
    localparam int AS_DBE = 7;
    localparam int AS_PIPE = 5;
    localparam int AS_BUS_E_CLOCK = 4;
    localparam int AS_STRB = 3;
    localparam int AS_RW = 2;
    localparam logic [7:0] ASSIGN_MASK = 8'hbc;
    // pull-up control field and the pins it reaches
    localparam int PULL_E_BIT = 4;
    localparam logic [7:0] PULL_MASK = 8'h8f;
    // port e pins that can only be inputs
    localparam logic [7:0] PE_IN_MASK = 8'h03;
    // register-following space
    localparam logic [15:0] RF_LO = 16'h0400;
    localparam logic [15:0] RF_HI = 16'h07ff;
    // reset values
    localparam logic [7:0] DIR_RST = 8'h00;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] ASSIGN_RST = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] SYNC_RST = 8'h00;
    localparam logic [7:0] BYTE_ONES = 8'hff;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    typedef enum logic [1:0] {mode_single, mode_wide, mode_narrow, mode_periph} mode_t;
    typedef enum logic [1:0] {bs_idle, bs_wait, bs_addr, bs_data} bus_state_t;
endpackage
`default_nettype wire

// >>> rtl/ext_bus_port.sv
// expansion bus port controller: port a/b/e registers, bus cycle engine
// assumes apb master on pclk; pins and e clock come from outside the domain
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module ext_bus_port (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_req,
    input wire logic [15:0] ext_addr,
    input wire logic [15:0] ext_wdata,
    input wire logic ext_write,
    input wire logic ext_wide,
    input wire logic ext_ram,
    output logic ext_ack,
    output logic [15:0] ext_rdata,
    input wire logic [1:0] pipe_status,
    input wire logic e_clk_in,
    input wire logic [7:0] pa_in,
    output logic [7:0] pa_out,
    output logic [7:0] pa_oe,
    input wire logic [7:0] pb_in,
    output logic [7:0] pb_out,
    output logic [7:0] pb_oe,
    input wire logic [7:0] pe_in,
    output logic [7:0] pe_out,
    output logic [7:0] pe_oe,
    output logic [7:0] pe_pullup,
    output logic nonmaskable_int_n,
    output logic maskable_int_n
);
    logic [7:0] pa_data_reg, pb_data_reg, pa_dir_reg, pb_dir_reg;
    logic [7:0] pe_data_reg, pe_dir_reg, assign_reg, mode_reg, pull_reg;
    logic [7:0] pa_s1_reg, pa_s2_reg, pb_s1_reg, pb_s2_reg, pe_s1_reg, pe_s2_reg;
    logic e_s1_reg, e_s2_reg, e_s3_reg;
    logic pready_reg, pslverr_reg, ext_ack_reg;
    logic [31:0] prdata_reg;
    logic [15:0] ext_rdata_reg, cy_addr_reg, cy_wdata_reg;
    logic cy_write_reg, cy_wide_reg, cy_swap_reg, cy_nar_reg, cy_apb_reg, cy_ram_reg;
    logic strb_reg, rw_reg;
    logic [7:0] pa_out_reg, pa_oe_reg, pb_out_reg, pb_oe_reg;
    logic [7:0] pe_out_reg, pe_oe_reg, pe_pull_reg;
    ebus_pkg::bus_state_t state_reg, state_next;
    ebus_pkg::mode_t cur_mode;
    logic expanded, periph, emulate_port_e_bit, narrow_follow_space_bit;
    logic [7:0] idx, rd_local;
    logic in_range, is_ab, is_pe, fwd, local_ok, err, apb_hit, apb_wr;
    logic e_rise, e_fall, bus_done, start_apb, start_user;
    logic [15:0] rq_addr, rd_bus;
    logic rq_nar, rq_wide, rq_swap, rq_write;
    logic [7:0] pa_o_next, pa_e_next, pb_o_next, pb_e_next;
    logic [7:0] alt, alt_out, alt_oe, pe_o_next, pe_e_next, pe_read;

    // mode decode
    assign cur_mode = ebus_pkg::mode_t'(mode_reg[ebus_pkg::MODE_HI:ebus_pkg::MODE_LO]);
    assign expanded = (cur_mode == ebus_pkg::mode_wide) || (cur_mode == ebus_pkg::mode_narrow);
    assign periph = (cur_mode == ebus_pkg::mode_periph);
    assign emulate_port_e_bit = mode_reg[ebus_pkg::EME_BIT];
    assign narrow_follow_space_bit = mode_reg[ebus_pkg::NARROW_FOLLOW_SPACE_BIT_BIT];

    // two-flop synchronisers for pins and e clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pa_s1_reg <= ebus_pkg::SYNC_RST;
            pa_s2_reg <= ebus_pkg::SYNC_RST;
            pb_s1_reg <= ebus_pkg::SYNC_RST;
            pb_s2_reg <= ebus_pkg::SYNC_RST;
            pe_s1_reg <= ebus_pkg::SYNC_RST;
            pe_s2_reg <= ebus_pkg::SYNC_RST;
            e_s1_reg <= 1'b0;
            e_s2_reg <= 1'b0;
            e_s3_reg <= 1'b0;
        end
        else
        begin
            pa_s1_reg <= pa_in;
            pa_s2_reg <= pa_s1_reg;
            pb_s1_reg <= pb_in;
            pb_s2_reg <= pb_s1_reg;
            pe_s1_reg <= pe_in;
            pe_s2_reg <= pe_s1_reg;
            e_s1_reg <= e_clk_in;
            e_s2_reg <= e_s1_reg;
            e_s3_reg <= e_s2_reg;
        end
    end
    assign e_rise = e_s2_reg & ~e_s3_reg;
    assign e_fall = ~e_s2_reg & e_s3_reg;

    // apb decode; mapped-out port registers forward to the bus in expanded modes, error in peripheral mode
    assign idx = paddr[9:2];
    assign in_range = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00);
    assign is_ab = (idx <= ebus_pkg::IDX_DB);
    assign is_pe = (idx == ebus_pkg::IDX_PE) || (idx == ebus_pkg::IDX_DE);
    assign fwd = in_range && expanded && (is_ab || (is_pe && emulate_port_e_bit));
    always_comb
    begin
        local_ok = 1'b0;
        if (in_range && !fwd)
        begin
            if (is_ab)
                local_ok = (cur_mode == ebus_pkg::mode_single);
            else if (periph && idx < ebus_pkg::IDX_BUS_LIMIT)
                local_ok = 1'b0;
            else
                local_ok = is_pe || idx == ebus_pkg::IDX_ASSIGN
                    || idx == ebus_pkg::IDX_MODE || idx == ebus_pkg::IDX_PULL;
        end
    end
    assign err = !fwd && !local_ok;
    assign apb_hit = psel && penable && !pready_reg;
    assign apb_wr = psel && penable && pready_reg && pwrite && !pslverr_reg && !fwd;

    // port read values: driven bits from register, input bits from pin
    assign pe_read = (pe_data_reg & pe_dir_reg & ~alt) | (pe_s2_reg & ~(pe_dir_reg & ~alt));
    always_comb
    begin
        case (idx)
            ebus_pkg::IDX_PA: rd_local = (pa_data_reg & pa_dir_reg) | (pa_s2_reg & ~pa_dir_reg);
            ebus_pkg::IDX_PB: rd_local = (pb_data_reg & pb_dir_reg) | (pb_s2_reg & ~pb_dir_reg);
            ebus_pkg::IDX_DA: rd_local = pa_dir_reg;
            ebus_pkg::IDX_DB: rd_local = pb_dir_reg;
            ebus_pkg::IDX_PE: rd_local = pe_read;
            ebus_pkg::IDX_DE: rd_local = pe_dir_reg;
            ebus_pkg::IDX_ASSIGN: rd_local = assign_reg;
            ebus_pkg::IDX_MODE: rd_local = mode_reg;
            ebus_pkg::IDX_PULL: rd_local = pull_reg;
            default: rd_local = ebus_pkg::BYTE_ZERO;
        endcase
    end

    // apb answer: local one cycle into access, forwarded at bus end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            if (apb_hit && fwd && bus_done && cy_apb_reg)
            begin
                pready_reg <= 1'b1;
                prdata_reg <= {24'h00_0000, rd_bus[7:0]};
            end
            else if (apb_hit && !fwd)
            begin
                pready_reg <= 1'b1;
                pslverr_reg <= err;
                prdata_reg <= {24'h00_0000, err ? ebus_pkg::BYTE_ZERO : rd_local};
            end
        end
    end

    // register writes take effect at the completing edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pa_data_reg <= ebus_pkg::DATA_RST;
            pb_data_reg <= ebus_pkg::DATA_RST;
            pa_dir_reg <= ebus_pkg::DIR_RST;
            pb_dir_reg <= ebus_pkg::DIR_RST;
            pe_data_reg <= ebus_pkg::DATA_RST;
            pe_dir_reg <= ebus_pkg::DIR_RST;
            assign_reg <= ebus_pkg::ASSIGN_RST;
            mode_reg <= ebus_pkg::MODE_RST;
            pull_reg <= ebus_pkg::DATA_RST;
        end
        else if (apb_wr)
        begin
            case (idx)
                ebus_pkg::IDX_PA: pa_data_reg <= pwdata[7:0];
                ebus_pkg::IDX_PB: pb_data_reg <= pwdata[7:0];
                ebus_pkg::IDX_DA: pa_dir_reg <= pwdata[7:0];
                ebus_pkg::IDX_DB: pb_dir_reg <= pwdata[7:0];
                ebus_pkg::IDX_PE: pe_data_reg <= pwdata[7:0];
                ebus_pkg::IDX_DE: pe_dir_reg <= pwdata[7:0] & ~ebus_pkg::PE_IN_MASK;
                ebus_pkg::IDX_ASSIGN: assign_reg <= pwdata[7:0] & ebus_pkg::ASSIGN_MASK;
                ebus_pkg::IDX_MODE: mode_reg <= pwdata[7:0] & ebus_pkg::MODE_MASK;
                ebus_pkg::IDX_PULL: pull_reg <= pwdata[7:0];
                default: pull_reg <= pull_reg;
            endcase
        end
    end

    // request selection and access type; apb forwarding has priority
    assign start_apb = (state_reg == ebus_pkg::bs_idle) && apb_hit && fwd;
    assign start_user = (state_reg == ebus_pkg::bs_idle) && ext_req && !ext_ack_reg
        && !start_apb;
    assign rq_addr = start_apb ? {ebus_pkg::BYTE_ZERO, idx} : ext_addr;
    assign rq_write = start_apb ? pwrite : ext_write;
    assign rq_nar = (cur_mode == ebus_pkg::mode_narrow)
        || (narrow_follow_space_bit && rq_addr >= ebus_pkg::RF_LO && rq_addr <= ebus_pkg::RF_HI);
    assign rq_wide = start_user && ext_wide && !rq_nar && (!rq_addr[0] || ext_ram);
    assign rq_swap = rq_wide && rq_addr[0];

    // bus cycle sequencer on sampled e clock edges
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ebus_pkg::bs_idle: if (start_apb || start_user) state_next = ebus_pkg::bs_wait;
            ebus_pkg::bs_wait: if (e_fall) state_next = ebus_pkg::bs_addr;
            ebus_pkg::bs_addr: if (e_rise) state_next = ebus_pkg::bs_data;
            ebus_pkg::bs_data: if (e_fall) state_next = ebus_pkg::bs_idle;
            default: state_next = ebus_pkg::bs_idle;
        endcase
    end
    assign bus_done = (state_reg == ebus_pkg::bs_data) && e_fall;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= ebus_pkg::bs_idle;
        else
            state_reg <= state_next;
    end

    // latch the cycle and its strobe coding at start
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cy_addr_reg <= 16'h0000;
            cy_wdata_reg <= 16'h0000;
            cy_write_reg <= 1'b0;
            cy_wide_reg <= 1'b0;
            cy_swap_reg <= 1'b0;
            cy_nar_reg <= 1'b0;
            cy_apb_reg <= 1'b0;
            cy_ram_reg <= 1'b0;
            strb_reg <= 1'b1;
            rw_reg <= 1'b1;
        end
        else if (start_apb || start_user)
        begin
            cy_addr_reg <= rq_addr;
            cy_wdata_reg <= start_apb ? {ebus_pkg::BYTE_ZERO, pwdata[7:0]} : ext_wdata;
            cy_write_reg <= rq_write;
            cy_wide_reg <= rq_wide;
            cy_swap_reg <= rq_swap;
            cy_nar_reg <= rq_nar;
            cy_apb_reg <= start_apb;
            cy_ram_reg <= start_user && ext_ram;
            strb_reg <= rq_swap ? 1'b1 : (rq_wide ? 1'b0 : ~rq_addr[0]);
            rw_reg <= ~rq_write;
        end
        else if (bus_done)
            rw_reg <= 1'b1;
    end

    // read data assembly from the sampled pins
    always_comb
    begin
        if (cy_nar_reg)
            rd_bus = {ebus_pkg::BYTE_ZERO, pa_s2_reg};
        else if (cy_swap_reg)
            rd_bus = {pb_s2_reg, pa_s2_reg};
        else if (cy_wide_reg)
            rd_bus = {pa_s2_reg, pb_s2_reg};
        else
            rd_bus = {ebus_pkg::BYTE_ZERO, cy_addr_reg[0] ? pb_s2_reg : pa_s2_reg};
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_ack_reg <= 1'b0;
            ext_rdata_reg <= 16'h0000;
        end
        else
        begin
            ext_ack_reg <= bus_done && !cy_apb_reg;
            if (bus_done && !cy_apb_reg)
                ext_rdata_reg <= cy_write_reg ? 16'h0000 : rd_bus;
        end
    end

    // port a/b: gpio in single chip mode, address then data in expanded and peripheral modes
    always_comb
    begin
        pa_o_next = pa_data_reg;
        pa_e_next = pa_dir_reg;
        pb_o_next = pb_data_reg;
        pb_e_next = pb_dir_reg;
        if (expanded || periph)
        begin
            pa_e_next = ebus_pkg::BYTE_ZERO;
            pb_e_next = ebus_pkg::BYTE_ZERO;
            if (state_reg == ebus_pkg::bs_addr)
            begin
                pa_o_next = cy_addr_reg[15:8];
                pb_o_next = cy_addr_reg[7:0];
                pa_e_next = ebus_pkg::BYTE_ONES;
                pb_e_next = ebus_pkg::BYTE_ONES;
            end
            else if (state_reg == ebus_pkg::bs_data)
            begin
                if (cy_nar_reg || !cy_wide_reg)
                    pa_o_next = cy_wdata_reg[7:0];
                else
                    pa_o_next = cy_swap_reg ? cy_wdata_reg[7:0] : cy_wdata_reg[15:8];
                if (cy_nar_reg)
                    pb_o_next = cy_addr_reg[7:0];
                else if (cy_wide_reg)
                    pb_o_next = cy_swap_reg ? cy_wdata_reg[15:8] : cy_wdata_reg[7:0];
                else
                    pb_o_next = cy_wdata_reg[7:0];
                pa_e_next = cy_write_reg ? ebus_pkg::BYTE_ONES : ebus_pkg::BYTE_ZERO;
                pb_e_next = (cy_write_reg || cy_nar_reg) ? ebus_pkg::BYTE_ONES
                    : ebus_pkg::BYTE_ZERO;
            end
        end
    end

    // port e alternate functions in expanded modes
    always_comb
    begin
        alt = ebus_pkg::BYTE_ZERO;
        alt[7] = expanded && assign_reg[ebus_pkg::AS_DBE];
        alt[6] = expanded && assign_reg[ebus_pkg::AS_PIPE];
        alt[5] = expanded && assign_reg[ebus_pkg::AS_PIPE];
        alt[4] = expanded && assign_reg[ebus_pkg::AS_BUS_E_CLOCK];
        alt[3] = expanded && assign_reg[ebus_pkg::AS_STRB];
        alt[2] = expanded && assign_reg[ebus_pkg::AS_RW];
        alt_out = {state_reg != ebus_pkg::bs_data, pipe_status, 1'b0, strb_reg, rw_reg,
            2'b00};
        alt_oe = ebus_pkg::BYTE_ONES & ~ebus_pkg::PE_IN_MASK & ~(8'h01 << ebus_pkg::AS_BUS_E_CLOCK);
    end
    for (genvar i = 0; i < 8; i++)
    begin : g_pe
        assign pe_o_next[i] = alt[i] ? alt_out[i] : pe_data_reg[i];
        assign pe_e_next[i] = alt[i] ? alt_oe[i]
            : (pe_dir_reg[i] & ~ebus_pkg::PE_IN_MASK[i]);
    end

    // registered pin drivers and pull-ups
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pa_out_reg <= ebus_pkg::BYTE_ZERO;
            pa_oe_reg <= ebus_pkg::BYTE_ZERO;
            pb_out_reg <= ebus_pkg::BYTE_ZERO;
            pb_oe_reg <= ebus_pkg::BYTE_ZERO;
            pe_out_reg <= ebus_pkg::BYTE_ZERO;
            pe_oe_reg <= ebus_pkg::BYTE_ZERO;
            pe_pull_reg <= ebus_pkg::BYTE_ZERO;
        end
        else
        begin
            pa_out_reg <= pa_o_next;
            pa_oe_reg <= pa_e_next;
            pb_out_reg <= pb_o_next;
            pb_oe_reg <= pb_e_next;
            pe_out_reg <= pe_o_next;
            pe_oe_reg <= pe_e_next;
            pe_pull_reg <= {8{pull_reg[ebus_pkg::PULL_E_BIT]}} & ebus_pkg::PULL_MASK
                & ~pe_e_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign ext_ack = ext_ack_reg;
    assign ext_rdata = ext_rdata_reg;
    assign pa_out = pa_out_reg;
    assign pa_oe = pa_oe_reg;
    assign pb_out = pb_out_reg;
    assign pb_oe = pb_oe_reg;
    assign pe_out = pe_out_reg;
    assign pe_oe = pe_oe_reg;
    assign pe_pullup = pe_pull_reg;
    assign nonmaskable_int_n = pe_s2_reg[0];
    assign maskable_int_n = pe_s2_reg[1];

    // checks
    a_byte_strobe: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg != ebus_pkg::bs_idle && !cy_wide_reg) |-> strb_reg == !cy_addr_reg[0])
        else $error("byte strobe coding wrong");
    a_wide_even: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg != ebus_pkg::bs_idle && cy_wide_reg && !cy_addr_reg[0]) |-> !strb_reg
        && rw_reg == !cy_write_reg)
        else $error("aligned word strobe wrong");
    a_swap_ram_only: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg != ebus_pkg::bs_idle && strb_reg && cy_addr_reg[0]) |-> cy_ram_reg
        && cy_wide_reg)
        else $error("swapped coding outside ram access");
    a_swap_low_half: assert property (@(posedge pclk) disable iff (!presetn)
        (state_reg == ebus_pkg::bs_data && cy_swap_reg && cy_write_reg)
        |=> pb_out_reg == cy_wdata_reg[15:8] && pa_out_reg == cy_wdata_reg[7:0])
        else $error("swapped halves misplaced");
    a_periph_gone: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready_reg && periph && in_range
        && idx < ebus_pkg::IDX_BUS_LIMIT) |-> pslverr_reg)
        else $error("bus register visible in peripheral mode");
    a_fwd_bus_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && pready_reg && fwd) |-> $past(bus_done) && !pslverr_reg)
        else $error("forwarded access answered without bus cycle");
    a_gpio_dir: assert property (@(posedge pclk) disable iff (!presetn)
        (cur_mode == ebus_pkg::mode_single) ##1 (cur_mode == ebus_pkg::mode_single)
        |-> pa_oe_reg == $past(pa_dir_reg) && pb_out_reg == $past(pb_data_reg))
        else $error("gpio direction not followed");
    a_pull_inputs: assert property (@(posedge pclk) disable iff (!presetn)
        (pe_pull_reg & (pe_oe_reg | ~ebus_pkg::PULL_MASK)) == ebus_pkg::BYTE_ZERO)
        else $error("pull-up on driven or wrong pin");
    a_irq_input: assert property (@(posedge pclk) disable iff (!presetn)
        (pe_oe_reg & ebus_pkg::PE_IN_MASK) == ebus_pkg::BYTE_ZERO)
        else $error("interrupt pin driven");
endmodule
`default_nettype wire

// >>> verification/ext_mem_model.sv
// far-side model: byte memory behind the multiplexed port a/b bus
// assumes strobe on pe_out[3], read/write on pe_out[2], data enable on pe_out[7]
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
    output logic e_clk,
    input wire logic [7:0] pa_out,
    input wire logic [7:0] pb_out,
    input wire logic [7:0] pe_out,
    output logic [7:0] pa_drv,
    output logic [7:0] pb_drv,
    output logic [15:0] cap_addr,
    output logic [2:0] cap_ctl
);
    logic [7:0] mem [0:255];
    logic [7:0] a;
    // free-running bus e clock; released lines start at a pattern
    initial
    begin
        e_clk = 1'b0;
        pa_drv = 8'h5a;
        pb_drv = 8'ha5;
    end
    always #32 e_clk = ~e_clk;
    // latch address and control at e rise, answer reads while e is high
    always @(posedge e_clk)
    begin
        cap_addr = {pa_out, pb_out};
        cap_ctl = {pe_out[3], pb_out[0], pe_out[2]};
        a = pb_out;
        pa_drv = ~pa_out;
        pb_drv = ~pb_out;
        if (pe_out[2] && pe_out[3] && pb_out[0])
        begin
            pb_drv = mem[a];
            pa_drv = mem[a + 8'h01];
        end
        else if (pe_out[2])
        begin
            pa_drv = mem[{a[7:1], 1'b0}];
            pb_drv = mem[{a[7:1], 1'b1}];
        end
    end
    // store write data at e fall while the data phase is flagged
    always @(negedge e_clk)
    begin
        if (!cap_ctl[0] && !pe_out[7] && cap_ctl[2] && cap_ctl[1])
        begin
            mem[a] = pb_out;
            mem[a + 8'h01] = pa_out;
        end
        else if (!cap_ctl[0] && !pe_out[7])
        begin
            if (!cap_ctl[1])
                mem[{a[7:1], 1'b0}] = pa_out;
            if (!cap_ctl[2])
                mem[{a[7:1], 1'b1}] = pb_out;
        end
    end
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
// self-checking bench for the expansion bus port controller
// assumes the package, the design and the far-side model compile first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, ext_ack, e_clk, nmi_n, irq_n;
    logic ext_req = 1'b0, ext_write = 1'b0, ext_wide = 1'b0, ext_ram = 1'b0;
    logic [15:0] ext_addr = 16'h0, ext_wdata = 16'h0, ext_rdata, xr, cap_addr, ad, d;
    logic [1:0] pipe_status = 2'b00;
    logic [2:0] cap_ctl;
    logic [7:0] pa_out, pa_oe, pb_out, pb_oe, pe_out, pe_oe, pe_pullup, pa_drv, pb_drv, v, k;
    logic [17:0] cases = 18'b100_101_111_001_010_000;
    int bad_count = 0, comparisons = 0, cycles = 0;
    // wire levels from the controller's enables; model drive or pull-high where released
    wire logic [7:0] pa_in = (pa_oe & pa_out) | (~pa_oe & pa_drv);
    wire logic [7:0] pb_in = (pb_oe & pb_out) | (~pb_oe & pb_drv);
    wire logic [7:0] pe_in = (pe_oe & pe_out) | ~pe_oe;
    always #2.5 pclk = ~pclk;
    ext_bus_port ext_bus_port_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ext_req(ext_req), .ext_addr(ext_addr),
        .ext_wdata(ext_wdata), .ext_write(ext_write), .ext_wide(ext_wide), .ext_ram(ext_ram),
        .ext_ack(ext_ack), .ext_rdata(ext_rdata), .pipe_status(pipe_status), .e_clk_in(e_clk),
        .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe), .pb_in(pb_in), .pb_out(pb_out),
        .pb_oe(pb_oe), .pe_in(pe_in), .pe_out(pe_out), .pe_oe(pe_oe), .pe_pullup(pe_pullup),
        .nonmaskable_int_n(nmi_n), .maskable_int_n(irq_n));
    ext_mem_model ext_mem_model_inst (.e_clk(e_clk), .pa_out(pa_out), .pb_out(pb_out),
        .pe_out(pe_out), .pa_drv(pa_drv), .pb_drv(pb_drv), .cap_addr(cap_addr),
        .cap_ctl(cap_ctl));
    // random pipe status and the hang limit
    always @(posedge pclk)
    begin
        pipe_status <= 2'($urandom);
        cycles++;
        if (cycles == 30000)
        begin
            bad_count++;
            conclude();
        end
    end
    task automatic conclude;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // one user bus cycle, held until ext_ack
    task automatic xfer(input logic w, input logic wd, input logic rm, input logic [15:0] wv);
        @(posedge pclk);
        ext_req <= 1'b1;
        ext_write <= w;
        ext_wide <= wd;
        ext_ram <= rm;
        ext_addr <= ad;
        ext_wdata <= wv;
        do @(posedge pclk); while (ext_ack !== 1'b1);
        xr = ext_rdata;
        ext_req <= 1'b0;
    endtask
    function automatic logic [1:0] ctl_of(input logic wd, input logic rm, input logic a0);
        if (wd && !a0)
            return 2'b00;
        if (wd && rm)
            return 2'b11;
        return a0 ? 2'b01 : 2'b10;
    endfunction
    initial
    begin
        void'($urandom(32'h9380ea9a));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, ebus_pkg::IDX_DA, 8'h00);
        chk(rd, 32'h0);
        chk(pa_oe, 8'h00);
        // single chip: direction then data for ports a and b
        for (int i = 0; i < 2; i++)
        begin
            v = 8'($urandom);
            apb(1'b1, 8'(i + 2), v);
            d = 16'($urandom);
            apb(1'b1, 8'(i), d[7:0]);
            apb(1'b0, 8'(i), 8'h00);
            chk(rd[7:0] & v, d[7:0] & v);
            apb(1'b0, 8'(i + 2), 8'h00);
            chk(rd, v);
            chk(i ? pb_oe : pa_oe, v);
            chk((i ? pb_out : pa_out) & v, d[7:0] & v);
        end
        apb(1'b1, ebus_pkg::IDX_PULL, 8'h10);
        apb(1'b1, ebus_pkg::IDX_DE, 8'h70);
        apb(1'b1, ebus_pkg::IDX_ASSIGN, 8'h8c);
        chk(pe_oe, 8'h70);
        chk(pe_pullup, 8'h8f);
        apb(1'b0, 8'h20, 8'h00);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        // wide expanded: port registers become bus cycles
        apb(1'b1, ebus_pkg::IDX_MODE, 8'h01);
        repeat (2) @(posedge pclk);
        chk(pe_pullup, 8'h03);
        chk(pe_oe, 8'hfc);
        chk({nmi_n, irq_n}, 2'b11);
        d = 16'($urandom);
        apb(1'b1, ebus_pkg::IDX_PA, d[7:0]);
        chk({er, cap_addr, cap_ctl}, {1'b0, 16'h0000, 3'b100});
        apb(1'b0, ebus_pkg::IDX_PA, 8'h00);
        chk(rd[7:0], d[7:0]);
        apb(1'b1, ebus_pkg::IDX_MODE, 8'h05);
        apb(1'b1, ebus_pkg::IDX_DE, d[15:8]);
        chk({er, cap_addr, cap_ctl}, {1'b0, 16'h0009, 3'b010});
        apb(1'b0, ebus_pkg::IDX_DE, 8'h00);
        chk(rd[7:0], d[15:8]);
        // user cycles: {wide, ram, a0} per case, write then read back
        for (int i = 0; i < 6; i++)
        begin
            k = {5'h0, cases[3 * i +: 3]};
            ad = {8'h20, 3'b010, 4'(i), k[0]};
            d = 16'($urandom);
            xfer(1'b1, k[2], k[1], d);
            chk({cap_addr, cap_ctl}, {ad, ctl_of(k[2], k[1], k[0]), 1'b0});
            xfer(1'b0, k[2], k[1], 16'h0000);
            chk(cap_ctl, {ctl_of(k[2], k[1], k[0]), 1'b1});
            if (k[2] && (!k[0] || k[1]))
                chk(xr, d);
            else
                chk(xr[7:0], d[7:0]);
            if (k[2] && k[1])
            begin
                xfer(1'b0, 1'b0, 1'b0, 16'h0000);
                chk(xr[7:0], d[15:8]);
            end
        end
        // narrow-follow space: a wide request shrinks to one byte on port a
        apb(1'b1, ebus_pkg::IDX_MODE, 8'h09);
        ad = 16'h0402;
        d = 16'($urandom);
        xfer(1'b1, 1'b1, 1'b0, d);
        chk(cap_ctl, 3'b100);
        xfer(1'b0, 1'b1, 1'b0, 16'h0000);
        chk(xr, {8'h00, d[7:0]});
        // peripheral mode: bus registers leave the map
        apb(1'b1, ebus_pkg::IDX_MODE, 8'h03);
        apb(1'b0, ebus_pkg::IDX_PE, 8'h00);
        chk(er, 1'b1);
        apb(1'b0, ebus_pkg::IDX_PA, 8'h00);
        chk(er, 1'b1);
        conclude();
    end
endmodule
`default_nettype wire
